/* hdl/fspa_pkg.sv */
// shared constants and carrier types of the flash sector protection block
// assumes a 20 MHz core clock and a 32-bit apb master with 8-bit byte addresses
package fspa_pkg;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_EXT = 8'h10;
    localparam logic [7:0] REG_RDADDR = 8'h14;
    localparam logic [7:0] REG_LOCKS = 8'h18;

    // control field positions
    localparam int CTRL_SCHEME_BIT = 0;
    localparam int CTRL_CMP_BIT = 1;
    localparam int CTRL_TB_BIT = 2;
    localparam int CTRL_BP_LSB = 3;
    localparam int CTRL_PU4_BIT = 7;
    // command register: opcode in the low nibble, four-byte address carried flag
    localparam int CMD_4B_BIT = 8;

    // reset values
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam logic [3:0] BP_RESET = 4'h0;

    // array geometry
    localparam int SECTORS = 8192;
    localparam int BLOCKS = 512;

    // timing: typical program and erase times, core clock period
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_TIME_NS = 700000;
    localparam int ERASE_TIME_NS = 45000000;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_WREN = 4'h1,
        CMD_PLOCK_PROG = 4'h2,
        CMD_PLOCK_ERASE = 4'h3,
        CMD_GUARD_CLR = 4'h4,
        CMD_DLOCK_SET = 4'h5,
        CMD_DLOCK_CLR = 4'h6,
        CMD_ENTER_4B = 4'h7,
        CMD_EXIT_4B = 4'h8,
        CMD_ARRAY_CHECK = 4'hA,
        CMD_READ_START = 4'hB,
        CMD_READ_STOP = 4'hC,
        CMD_SW_RESET = 4'hD,
        CMD_DLOCK_ALL_SET = 4'hE,
        CMD_DLOCK_ALL_CLR = 4'hF
    } fspa_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_PREP = 2'b10,
        ST_ERASE = 2'b11
    } fspa_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } fspa_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fspa_apb_rsp_t;

endpackage

/* hdl/fspa_pin_sync.sv */
// two-flop synchroniser with rising edge detect for the serial clock pin
// assumes the pin is slow against the core clock (several core cycles per half period)
`timescale 1ns/10ps
module fspa_pin_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin and edge
    input wire logic pin,
    output logic rise
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } fspa_sync_t;

    fspa_sync_t st_ff;
    fspa_sync_t nxt_st;

    // the edge detect only looks at the second and third stages
    always_comb begin
        nxt_st = st_ff;
        nxt_st.meta = pin;
        nxt_st.sync = st_ff.meta;
        nxt_st.last = st_ff.sync;
        if (!rst_n) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign rise = st_ff.sync & ~st_ff.last;

endmodule

/* hdl/fspa_block_map.sv */
// block protection map: decides whether a 64KB block is protected
// purely combinational, fed with the block number of the addressed location
`timescale 1ns/10ps
module fspa_block_map (
    // map settings
    input wire logic complement,
    input wire logic top_bottom,
    input wire logic [3:0] level,
    // block under test and result
    input wire logic [8:0] block,
    output logic protected_o
);
    import fspa_pkg::*;

    logic cmp_prot;
    logic [9:0] span;

    // complement map: level 0 protects all, 1..9 leave 2^(level-1) blocks open
    always_comb begin
        span = 10'h001 << (level - 4'h1);
        if (level == 4'h0) begin
            cmp_prot = 1'b1;
        end else if (level[3] & (level[2] | level[1])) begin
            cmp_prot = 1'b0;
        end else if (!top_bottom) begin
            cmp_prot = {1'b0, block} < (10'(BLOCKS) - span);
        end else begin
            cmp_prot = {1'b0, block} >= span;
        end
    end

    // without complement the map is the exact inverse of the complement map
    assign protected_o = complement ? cmp_prot : ~cmp_prot;

endmodule

/* hdl/fspa_sector_protect.sv */
// sector protection, persistent and dynamic locks, extended address register
// assumes an apb master on the core clock and a serial clock pin from the host side
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps

// Summary of operation
// - complement map, top/bottom 0: all but top 2^(level-1) blocks protected
// - complement map, top/bottom 1: all above bottom 2^(level-1) blocks protected
// - complement map: level 0000 protects all; levels 110x and 1x1x protect nothing
// - a sector is protected when the selected mechanism marks it; program/erase refused
// - each sector has persistent bit (0 protects) and dynamic bit (1 protects)
// - guard bit is 1 after power-on and hardware reset
// - a command clears the guard bit; nothing sets it until reset
// - guard 0 makes persistent program or erase fail without change
// - persistent bits program one at a time to 0, erase all to 1
// - persistent program takes page time, erase sector time; busy readable
// - device preprograms persistent array itself before erasing it
// - dynamic lock command sets or clears a sector bit, any number of times
// - dynamic bit matters only when the persistent bit is 1
// - dynamic bits lost on reset; persistent bits survive it
// - extended address register supplies bits 31..24 in 3-byte mode only
// - in 3-byte mode extended bit 24 selects lower or upper 128Mb
// - power-up width bit or enter-4-byte command makes 4-byte addressing
// - each 4-byte address command overwrites the extended register top byte
// - extended address register clears on power-up, software and hardware reset
// - continuous read runs from one segment into the other
// - segment crossing during read leaves the extended register unchanged
// - scheme select 0 uses the block map, 1 uses per-sector locks together with the block map
// - program or erase aimed at a protected area sets write-fail
module fspa_sector_protect #(
    parameter int PROG_CYCLES_P = fspa_pkg::PROG_CYCLES,
    parameter int ERASE_CYCLES_P = fspa_pkg::ERASE_CYCLES
) (
    // clock and resets
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic NV_INIT_N,
    // register bus
    input wire fspa_pkg::fspa_apb_req_t APB_REQ,
    output fspa_pkg::fspa_apb_rsp_t APB_RSP,
    // serial clock pin of the link
    input wire logic LINK_CLK,
    // status
    output logic BUSY,
    output logic WRITE_FAIL,
    output logic ADDR_WIDTH_4B
);
    import fspa_pkg::*;

    typedef struct packed {
        fspa_state_t state;
        logic [19:0] timer;
        logic [12:0] sector;
        logic guard;
        logic wfail;
        logic addr4;
        logic [7:0] ext;
        logic scheme;
        logic cmp;
        logic tb;
        logic [3:0] bp;
        logic pu_addr4;
        logic [31:0] addr;
        logic reading;
        logic [24:0] rd_addr;
        logic [2:0] bitcnt;
        logic last_prot;
        logic [31:0] prdata;
        logic slverr;
        logic [SECTORS-1:0] persistent_sector_lock;
        logic [SECTORS-1:0] dynamic_sector_lock;
    } fspa_state_reg_t;

    fspa_state_reg_t st_ff;
    fspa_state_reg_t nxt_st;

    logic link_rise;
    logic map_prot;
    logic cmd_fire;
    logic carry4;
    logic use4;
    logic [24:0] cmd_eff;
    logic [12:0] cmd_sector;
    logic asp_prot;
    logic cmd_prot;
    logic [24:0] lk_eff;
    fspa_cmd_t cmd;

    // 25-bit array address: 4-byte mode takes it whole, 3-byte mode borrows bit 24
    function automatic logic [24:0] eff_addr(input logic [31:0] a, input logic [7:0] ext, input logic w4);
        eff_addr = w4 ? a[24:0] : {ext[0], a[23:0]};
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == REG_CTRL) || (a == REG_CMD) || (a == REG_ADDR) || (a == REG_STATUS)
            || (a == REG_EXT) || (a == REG_RDADDR) || (a == REG_LOCKS);
    endfunction

    function automatic logic has_addr(input fspa_cmd_t c);
        has_addr = (c == CMD_PLOCK_PROG) || (c == CMD_PLOCK_ERASE) || (c == CMD_DLOCK_SET)
            || (c == CMD_DLOCK_CLR) || (c == CMD_ARRAY_CHECK) || (c == CMD_READ_START);
    endfunction

    fspa_pin_sync u_link_sync (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .pin(LINK_CLK),
        .rise(link_rise)
    );

    fspa_block_map u_block_map (
        .complement(st_ff.cmp),
        .top_bottom(st_ff.tb),
        .level(st_ff.bp),
        .block(cmd_eff[24:16]),
        .protected_o(map_prot)
    );

    // command decode straight from the bus write data
    assign cmd_fire = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & (APB_REQ.paddr == REG_CMD);
    assign cmd = fspa_cmd_t'(APB_REQ.pwdata[3:0]);
    assign carry4 = APB_REQ.pwdata[CMD_4B_BIT];
    assign use4 = st_ff.addr4 | carry4;
    assign cmd_eff = eff_addr(st_ff.addr, st_ff.ext, use4);
    assign cmd_sector = cmd_eff[24:12];
    assign lk_eff = eff_addr(st_ff.addr, st_ff.ext, st_ff.addr4);

    // persistent 0 protects whatever the dynamic bit says
    assign asp_prot = ~st_ff.persistent_sector_lock[cmd_sector] | st_ff.dynamic_sector_lock[cmd_sector];
    // with sector locks selected the block map still applies: either one protecting is enough
    assign cmd_prot = st_ff.scheme ? (asp_prot | map_prot) : map_prot;

    // whole next-state computation: bus, commands, timed operations, read stream, resets
    always_comb begin
        nxt_st = st_ff;
        // read data is latched in the setup phase so the access phase needs no wait
        if (APB_REQ.psel && !APB_REQ.penable) begin
            nxt_st.slverr = ~is_mapped(APB_REQ.paddr);
            nxt_st.prdata = 32'h0000_0000;
            unique case (APB_REQ.paddr)
                REG_CTRL: begin
                    nxt_st.prdata[CTRL_SCHEME_BIT] = st_ff.scheme;
                    nxt_st.prdata[CTRL_CMP_BIT] = st_ff.cmp;
                    nxt_st.prdata[CTRL_TB_BIT] = st_ff.tb;
                    nxt_st.prdata[CTRL_BP_LSB +: 4] = st_ff.bp;
                    nxt_st.prdata[CTRL_PU4_BIT] = st_ff.pu_addr4;
                end
                REG_ADDR: nxt_st.prdata = st_ff.addr;
                REG_STATUS: nxt_st.prdata[5:0] = {st_ff.last_prot, st_ff.reading, st_ff.addr4,
                    st_ff.guard, st_ff.wfail, st_ff.state != ST_IDLE};
                REG_EXT: nxt_st.prdata[7:0] = st_ff.ext;
                REG_RDADDR: nxt_st.prdata[24:0] = st_ff.rd_addr;
                REG_LOCKS: nxt_st.prdata[1:0] = {st_ff.dynamic_sector_lock[lk_eff[24:12]], st_ff.persistent_sector_lock[lk_eff[24:12]]};
                default: nxt_st.prdata = 32'h0000_0000;
            endcase
        end
        // plain register writes
        if (APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite) begin
            if (APB_REQ.paddr == REG_CTRL) begin
                nxt_st.scheme = APB_REQ.pwdata[CTRL_SCHEME_BIT];
                nxt_st.cmp = APB_REQ.pwdata[CTRL_CMP_BIT];
                nxt_st.tb = APB_REQ.pwdata[CTRL_TB_BIT];
                nxt_st.bp = APB_REQ.pwdata[CTRL_BP_LSB +: 4];
                nxt_st.pu_addr4 = APB_REQ.pwdata[CTRL_PU4_BIT];
            end
            if (APB_REQ.paddr == REG_ADDR) begin
                nxt_st.addr = APB_REQ.pwdata;
            end
            if (APB_REQ.paddr == REG_EXT) begin
                nxt_st.ext = APB_REQ.pwdata[7:0];
            end
        end
        // commands are ignored while a persistent program or erase runs
        if (cmd_fire && st_ff.state == ST_IDLE) begin
            if (use4 && has_addr(cmd)) begin
                nxt_st.ext = st_ff.addr[31:24];
            end
            unique case (cmd)
                CMD_WREN: nxt_st.wfail = 1'b0;
                CMD_PLOCK_PROG: begin
                    if (!st_ff.guard) begin
                        nxt_st.wfail = 1'b1;
                    end else begin
                        nxt_st.state = ST_PROG;
                        nxt_st.timer = 20'(PROG_CYCLES_P - 1);
                        nxt_st.sector = cmd_sector;
                    end
                end
                CMD_PLOCK_ERASE: begin
                    if (!st_ff.guard) begin
                        nxt_st.wfail = 1'b1;
                    end else begin
                        nxt_st.state = ST_PREP;
                        nxt_st.timer = 20'(PROG_CYCLES_P - 1);
                    end
                end
                CMD_GUARD_CLR: nxt_st.guard = 1'b0;
                CMD_DLOCK_SET: nxt_st.dynamic_sector_lock[cmd_sector] = 1'b1;
                CMD_DLOCK_CLR: nxt_st.dynamic_sector_lock[cmd_sector] = 1'b0;
                CMD_DLOCK_ALL_SET: nxt_st.dynamic_sector_lock = '1;
                CMD_DLOCK_ALL_CLR: nxt_st.dynamic_sector_lock = '0;
                CMD_ENTER_4B: nxt_st.addr4 = 1'b1;
                CMD_EXIT_4B: nxt_st.addr4 = 1'b0;
                CMD_ARRAY_CHECK: begin
                    nxt_st.last_prot = cmd_prot;
                    if (cmd_prot) begin
                        nxt_st.wfail = 1'b1;
                    end
                end
                CMD_READ_START: begin
                    nxt_st.reading = 1'b1;
                    nxt_st.rd_addr = cmd_eff;
                    nxt_st.bitcnt = 3'h0;
                end
                CMD_READ_STOP: nxt_st.reading = 1'b0;
                CMD_SW_RESET: begin
                    nxt_st.dynamic_sector_lock = '0;
                    nxt_st.ext = EXT_RESET;
                    nxt_st.addr4 = st_ff.pu_addr4;
                    nxt_st.wfail = 1'b0;
                    nxt_st.reading = 1'b0;
                end
                default: nxt_st.reading = st_ff.reading;
            endcase
        end
        // timed persistent-lock operations
        unique case (st_ff.state)
            // idle leaves the timer alone: a command in this cycle may just have loaded it
            ST_IDLE: begin
            end
            ST_PROG: begin
                if (st_ff.timer == 20'h00000) begin
                    nxt_st.persistent_sector_lock[st_ff.sector] = 1'b0;
                    nxt_st.state = ST_IDLE;
                end else begin
                    nxt_st.timer = st_ff.timer - 20'h00001;
                end
            end
            ST_PREP: begin
                // preprogramming evens out cell wear before the bulk erase
                if (st_ff.timer == 20'h00000) begin
                    nxt_st.persistent_sector_lock = '0;
                    nxt_st.state = ST_ERASE;
                    nxt_st.timer = 20'(ERASE_CYCLES_P - 1);
                end else begin
                    nxt_st.timer = st_ff.timer - 20'h00001;
                end
            end
            ST_ERASE: begin
                if (st_ff.timer == 20'h00000) begin
                    nxt_st.persistent_sector_lock = '1;
                    nxt_st.state = ST_IDLE;
                end else begin
                    nxt_st.timer = st_ff.timer - 20'h00001;
                end
            end
        endcase
        // one byte per eight serial clocks; the 25-bit counter wraps over both segments
        if (st_ff.reading && link_rise) begin
            nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
            if (st_ff.bitcnt == 3'h7) begin
                nxt_st.rd_addr = st_ff.rd_addr + 25'h0000001;
            end
        end
        // factory state of the non-volatile bits
        if (!NV_INIT_N) begin
            nxt_st.persistent_sector_lock = '1;
            nxt_st.scheme = 1'b0;
            nxt_st.cmp = 1'b0;
            nxt_st.tb = 1'b0;
            nxt_st.bp = BP_RESET;
            nxt_st.pu_addr4 = 1'b0;
        end
        // hardware reset clears only volatile state; persistent bits are kept
        if (!RST_N) begin
            nxt_st.state = ST_IDLE;
            nxt_st.timer = 20'h00000;
            nxt_st.sector = 13'h0000;
            nxt_st.guard = 1'b1;
            nxt_st.wfail = 1'b0;
            nxt_st.addr4 = st_ff.pu_addr4;
            nxt_st.ext = EXT_RESET;
            nxt_st.addr = 32'h0000_0000;
            nxt_st.reading = 1'b0;
            nxt_st.rd_addr = 25'h0000000;
            nxt_st.bitcnt = 3'h0;
            nxt_st.last_prot = 1'b0;
            nxt_st.prdata = 32'h0000_0000;
            nxt_st.slverr = 1'b0;
            nxt_st.dynamic_sector_lock = '0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        st_ff <= nxt_st;
    end

    // zero-wait slave: ready in every access phase
    assign APB_RSP.prdata = st_ff.prdata;
    assign APB_RSP.pready = 1'b1;
    assign APB_RSP.pslverr = st_ff.slverr & APB_REQ.psel & APB_REQ.penable;
    assign BUSY = st_ff.state != ST_IDLE;
    assign WRITE_FAIL = st_ff.wfail;
    assign ADDR_WIDTH_4B = st_ff.addr4;

    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_plock_locked;
        cmd_fire && st_ff.state == ST_IDLE && !st_ff.guard && (cmd == CMD_PLOCK_PROG || cmd == CMD_PLOCK_ERASE);
    endsequence
    sequence s_prog_accept;
        cmd_fire && st_ff.state == ST_IDLE && st_ff.guard && cmd == CMD_PLOCK_PROG;
    endsequence
    sequence s_prog_end;
        st_ff.state == ST_PROG && st_ff.timer == 20'h00000;
    endsequence
    sequence s_erase_end;
        st_ff.state == ST_ERASE && st_ff.timer == 20'h00000;
    endsequence

    chk_guard_stays_clear: assert property (!st_ff.guard |=> !st_ff.guard)
        else $error("guard bit returned to 1 without reset");
    chk_guard_blocks_plock: assert property (s_plock_locked |=> st_ff.wfail && !BUSY && $stable(st_ff.persistent_sector_lock))
        else $error("persistent lock command ran while guard was clear");
    chk_prog_timer_load: assert property (s_prog_accept |=> BUSY && st_ff.timer == 20'(PROG_CYCLES_P - 1))
        else $error("persistent program did not start with full page time");
    chk_prog_single_bit: assert property (s_prog_end |=> !st_ff.persistent_sector_lock[st_ff.sector] && !BUSY)
        else $error("persistent program did not clear its sector bit");
    chk_erase_all_ones: assert property (s_erase_end |=> (&st_ff.persistent_sector_lock) && !BUSY)
        else $error("persistent erase did not set every bit");
    chk_ext_4b_update: assert property (cmd_fire && !BUSY && use4 && has_addr(cmd) && cmd != CMD_SW_RESET
        |=> st_ff.ext == $past(st_ff.addr[31:24]))
        else $error("four-byte address did not reload extended register");
    chk_read_wrap: assert property (st_ff.reading && link_rise && st_ff.bitcnt == 3'h7
        && st_ff.rd_addr == 25'h1FFFFFF && !cmd_fire |=> st_ff.rd_addr == 25'h0000000 && $stable(st_ff.ext))
        else $error("read stream did not wrap to array start");
    chk_segment_cross: assert property (st_ff.reading && link_rise && st_ff.bitcnt == 3'h7
        && st_ff.rd_addr == 25'h0FFFFFF && !cmd_fire |=> st_ff.rd_addr == 25'h1000000 && $stable(st_ff.ext))
        else $error("segment crossing failed or touched extended register");
    chk_protect_fail: assert property (cmd_fire && !BUSY && cmd == CMD_ARRAY_CHECK && cmd_prot
        |=> st_ff.wfail && st_ff.last_prot)
        else $error("protected target did not raise write fail");
    chk_ppb_dominates: assert property (st_ff.scheme && !st_ff.persistent_sector_lock[cmd_sector] |-> cmd_prot)
        else $error("sector with persistent bit 0 seen as unprotected");
    chk_reset_values: assert property ($rose(RST_N) |-> st_ff.guard && st_ff.ext == EXT_RESET && st_ff.dynamic_sector_lock == '0)
        else $error("volatile protection state wrong after reset");

endmodule

/* testbench/fspa_host_model.sv */
// host-side serial clock source: eight clocks per byte, 400 ns period
// assumes the bench calls send_bytes; the clock rests low between frames
`timescale 1ns/10ps
module fspa_host_model (
    // serial clock towards the device
    output logic LINK_CLK
);
    // idle low so no stray edge is counted outside a frame
    initial LINK_CLK = 1'h0;

    // one frame of n bytes; edges land on core clock edges, so non-blocking to avoid a sampling race
    task automatic send_bytes(input int n);
        repeat (n * 8) begin
            #200 LINK_CLK <= 1'h1;
            #200 LINK_CLK <= 1'h0;
        end
    endtask
endmodule

/* testbench/fspa_sector_protect_tb.sv */
// self-checking bench: table of block map cases, then lock, reset and address tests
// assumes the design package and the host clock model are compiled first
`timescale 1ns/10ps
module fspa_sector_protect_tb;
    import fspa_pkg::*;
    localparam int PROG_P = 20;
    localparam int ERASE_P = 40;
    typedef struct packed {logic [7:0] ctrl; logic [31:0] addr; logic prot;} fspa_row_t;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic nv_init_n = 1'h0;
    fspa_apb_req_t req = '0;
    fspa_apb_rsp_t rsp;
    logic link_clk, busy, write_fail, addr_4b, slverr;
    logic [31:0] rdat;
    int miscompares = 0;
    int tests_run = 0;
    int cnt;
    // control word, address in 4-byte mode, protected
    fspa_row_t rows [13] = '{'{8'h02, 32'h0, 1'h1},
        '{8'h0A, 32'h01FEFFFF, 1'h1}, '{8'h0A, 32'h01FF0000, 1'h0},
        '{8'h0E, 32'h0000FFFF, 1'h0}, '{8'h0E, 32'h00010000, 1'h1},
        '{8'h4A, 32'h00FFFFFF, 1'h1}, '{8'h4A, 32'h01000000, 1'h0},
        '{8'h4E, 32'h00FFFFFF, 1'h0}, '{8'h4E, 32'h01000000, 1'h1},
        '{8'h66, 32'h0, 1'h0}, '{8'h52, 32'h01FFFFFF, 1'h0},
        '{8'h5A, 32'h0, 1'h0}, '{8'h6E, 32'h01FFFFFF, 1'h0}};

    // 20 MHz core clock
    always #25 core_clk = ~core_clk;

    fspa_sector_protect #(.PROG_CYCLES_P(PROG_P), .ERASE_CYCLES_P(ERASE_P)) dut (
        .CORE_CLK(core_clk), .RST_N(rst_n), .NV_INIT_N(nv_init_n), .APB_REQ(req), .APB_RSP(rsp),
        .LINK_CLK(link_clk), .BUSY(busy), .WRITE_FAIL(write_fail), .ADDR_WIDTH_4B(addr_4b));
    fspa_host_model host (.LINK_CLK(link_clk));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        req <= '{1'h1, 1'h0, wr, a, d};
        @(posedge core_clk);
        req.penable <= 1'h1;
        do @(posedge core_clk); while (rsp.pready !== 1'h1 && n++ < 64);
        if (n >= 64) miscompares++;
        rdat = rsp.prdata;
        slverr = rsp.pslverr;
        req <= '0;
    endtask

    task automatic cmd(input logic [31:0] a, input fspa_cmd_t op);
        apb(1'h1, REG_ADDR, a);
        apb(1'h1, REG_CMD, {28'h0, op});
    endtask

    task automatic locks(input logic [31:0] a, input logic [31:0] exp);
        apb(1'h1, REG_ADDR, a);
        apb(1'h0, REG_LOCKS, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic prot(input logic [31:0] a, input logic exp);
        cmd(a, CMD_ARRAY_CHECK);
        apb(1'h0, REG_STATUS, 32'h0);
        chk(rdat[5], exp);
    endtask

    // busy length must sit close to the programmed count; a stuck counter shows here
    task automatic busy_span(input int lo, input int hi);
        cnt = 0;
        @(posedge core_clk);
        while (busy === 1'h1 && cnt < 2000) begin
            cnt++;
            @(posedge core_clk);
        end
        chk(cnt >= lo && cnt <= hi, 1'h1);
    endtask

    task automatic hw_reset();
        @(posedge core_clk);
        rst_n <= 1'h0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
    endtask

    task automatic final_report();
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
        nv_init_n <= 1'h1;
        apb(1'h0, REG_STATUS, 32'h0);
        chk(rdat[3:0], 4'h4);
        apb(1'h0, REG_EXT, 32'h0);
        chk(rdat, 32'h0);
        apb(1'h0, 8'h1C, 32'h0);
        chk({slverr, rdat[30:0]}, 32'h80000000); // unmapped word is refused
        cmd(32'h0, CMD_ENTER_4B);
        @(posedge core_clk);
        chk(addr_4b, 1'h1);
        foreach (rows[i]) begin
            apb(1'h1, REG_CTRL, {24'h0, rows[i].ctrl});
            cmd(32'h0, CMD_WREN);
            prot(rows[i].addr, rows[i].prot);
            chk(write_fail, rows[i].prot);
        end
        // per-sector locks
        apb(1'h1, REG_CTRL, 32'h1);
        locks(32'h3000, 32'h1);
        prot(32'h3000, 1'h0);
        cmd(32'h3000, CMD_DLOCK_SET);
        prot(32'h3000, 1'h1);
        cmd(32'h3000, CMD_DLOCK_CLR);
        prot(32'h3000, 1'h0);
        apb(1'h1, REG_CTRL, 32'h3);
        prot(32'h3000, 1'h1);
        apb(1'h1, REG_CTRL, 32'h1);
        cmd(32'h3000, CMD_PLOCK_PROG);
        busy_span(PROG_P - 2, PROG_P + 3);
        locks(32'h3000, 32'h0);
        locks(32'h4000, 32'h1);
        prot(32'h3000, 1'h1);
        cmd(32'h3000, CMD_PLOCK_ERASE);
        busy_span(PROG_P + ERASE_P - 2, PROG_P + ERASE_P + 4);
        locks(32'h3000, 32'h1);
        cmd(32'h3000, CMD_PLOCK_PROG);
        busy_span(PROG_P - 2, PROG_P + 3);
        // guard cleared: persistent commands must fail without effect
        cmd(32'h0, CMD_GUARD_CLR);
        apb(1'h0, REG_STATUS, 32'h0);
        chk(rdat[2], 1'h0);
        cmd(32'h0, CMD_WREN);
        cmd(32'h4000, CMD_PLOCK_PROG);
        repeat (2) @(posedge core_clk);
        chk({busy, write_fail}, 2'h1);
        cmd(32'h0, CMD_WREN);
        cmd(32'h3000, CMD_PLOCK_ERASE);
        repeat (2) @(posedge core_clk);
        chk({busy, write_fail}, 2'h1);
        locks(32'h4000, 32'h1);
        locks(32'h3000, 32'h0);
        cmd(32'h5000, CMD_DLOCK_SET);
        cmd(32'h0, CMD_SW_RESET);
        locks(32'h5000, 32'h1);
        apb(1'h0, REG_STATUS, 32'h0);
        chk(rdat[2], 1'h0);
        cmd(32'h5000, CMD_DLOCK_SET);
        hw_reset();
        apb(1'h0, REG_STATUS, 32'h0);
        chk(rdat[3:2], 2'h1);
        locks(32'h3000, 32'h0);
        locks(32'h5000, 32'h1);
        // extended address picks the segment in 3-byte mode
        apb(1'h1, REG_EXT, 32'h1);
        locks(32'h3000, 32'h1);
        cmd(32'hFFFFFE, CMD_READ_START);
        apb(1'h0, REG_RDADDR, 32'h0);
        chk(rdat, 32'h1FFFFFE);
        host.send_bytes(2);
        repeat (4) @(posedge core_clk);
        apb(1'h0, REG_RDADDR, 32'h0);
        chk(rdat, 32'h0);
        apb(1'h0, REG_EXT, 32'h0);
        chk(rdat, 32'h1);
        // second stream from the top of the lower segment into the upper one
        apb(1'h1, REG_EXT, 32'h0);
        cmd(32'hFFFFFF, CMD_READ_START);
        host.send_bytes(1);
        repeat (4) @(posedge core_clk);
        apb(1'h0, REG_RDADDR, 32'h0);
        chk(rdat, 32'h1000000);
        apb(1'h0, REG_EXT, 32'h0);
        chk(rdat, 32'h0);
        cmd(32'h0, CMD_READ_STOP);
        // power-up width bit, then a 4-byte address command
        apb(1'h1, REG_CTRL, 32'h81);
        hw_reset();
        apb(1'h0, REG_EXT, 32'h0);
        chk({addr_4b, rdat[30:0]}, 32'h80000000);
        cmd(32'h01003000, CMD_DLOCK_SET);
        apb(1'h0, REG_EXT, 32'h0);
        chk(rdat, 32'h1);
        locks(32'h01003000, 32'h3);
        cmd(32'h0, CMD_SW_RESET);
        apb(1'h0, REG_EXT, 32'h0);
        chk(rdat, 32'h0);
        // bulk dynamic lock commands, then back to 3-byte mode
        cmd(32'h0, CMD_DLOCK_ALL_SET);
        locks(32'h01003000, 32'h3);
        cmd(32'h0, CMD_DLOCK_ALL_CLR);
        locks(32'h01003000, 32'h1);
        cmd(32'h0, CMD_EXIT_4B);
        @(posedge core_clk);
        chk(addr_4b, 1'h0);
        // one command carrying a 4-byte address in 3-byte mode still reloads the extended register
        apb(1'h1, REG_ADDR, 32'h01005000);
        apb(1'h1, REG_CMD, 32'h00000105);
        apb(1'h0, REG_EXT, 32'h0);
        chk(rdat, 32'h1);
        locks(32'h00005000, 32'h3);
        final_report();
    end

    // watchdog: the run needs a few thousand cycles at most
    initial begin
        #2000000;
        miscompares++;
        final_report();
    end
endmodule
